//--- core/nsx_regs.svh
// offsets, field positions, reset values and encodings for the nibble swap / xor / direction unit
`ifndef NSX_REGS_SVH
`define NSX_REGS_SVH

`define NSX_DATA_W        8
`define NSX_ADDR_W        5
`define NSX_DIR_PORT_A    5'h06
`define NSX_DIR_PORT_B    5'h07
`define NSX_DIR_RESET     8'hFF
`define NSX_ACC_RESET     8'h00
`define NSX_DEST_ACC      1'b0
`define NSX_DEST_FILE     1'b1
`define NSX_LO_MSB        3
`define NSX_HI_LSB        4

`endif

//--- core/nsx_pkg.sv
// types shared by the nibble swap / xor / direction unit
package nsx_pkg;

  typedef enum logic [2:0] {
    nsx_op_none,
    nsx_op_nibble_swap,
    nsx_op_direction_load,
    nsx_op_xor_literal,
    nsx_op_xor_file
  } nsx_op_type;

  typedef enum logic [1:0] {
    nsx_st_idle,
    nsx_st_write
  } nsx_state_type;

endpackage

//--- core/nsx_alu.sv
// combinational result unit: nibble swap and exclusive or
`timescale 1ns/1ps
`include "nsx_regs.svh"

module nsx_alu (
  // operation select
  input  wire nsx_pkg::nsx_op_type       op,
  // operands
  input  wire logic [`NSX_DATA_W-1:0]    acc,
  input  wire logic [`NSX_DATA_W-1:0]    file_data,
  input  wire logic [`NSX_DATA_W-1:0]    literal,
  // result
  output logic      [`NSX_DATA_W-1:0]    result,
  output logic                           zero
);

  always_comb begin
    result = file_data;
    case (op)
      nsx_pkg::nsx_op_nibble_swap: begin
        result = {file_data[`NSX_LO_MSB:0],
                  file_data[`NSX_DATA_W-1:`NSX_HI_LSB]}; // RL1
      end
      nsx_pkg::nsx_op_xor_literal: begin
        result = acc ^ literal; // RL4
      end
      nsx_pkg::nsx_op_xor_file: begin
        result = acc ^ file_data; // RL5
      end
      default: begin
        result = acc;
      end
    endcase
    zero = (result == 8'h00); // RL7
  end

endmodule // nsx_alu

//--- core/nsx_exec.sv
// execution unit for nibble swap, direction load and the two xor instructions
`timescale 1ns/1ps
`include "nsx_regs.svh"

// Notes on behaviour
// [RL1] nibble swap puts file bits 3:0 into 7:4 and 7:4 into 3:0, no flags
// [RL2] nibble swap result goes to accumulator when destination is 0, else file
// [RL3] direction load copies accumulator into direction register 6 or 7, no flags
// [RL4] xor literal: accumulator xor 8-bit immediate into accumulator, zero flag updated
// [RL5] xor file: accumulator xor file register, only zero flag updated
// [RL6] xor file result goes to accumulator when destination is 0, else file
// [RL7] zero flag set when the 8-bit result is all zeros, cleared otherwise
module nsx_exec (
  // clock and reset
  input  wire  logic                      sys_clk,
  input  wire  logic                      rst_n,
  // instruction issue, one cycle per instruction
  input  wire  logic                      issue,
  input  wire  nsx_pkg::nsx_op_type       op,
  input  wire  logic [`NSX_ADDR_W-1:0]    file_addr,
  input  wire  logic                      dest_sel,
  input  wire  logic [`NSX_DATA_W-1:0]    literal,
  // file register read data for file_addr, same cycle
  input  wire  logic [`NSX_DATA_W-1:0]    file_rdata,
  // file register write-back
  output logic                            file_we,
  output logic       [`NSX_ADDR_W-1:0]    file_waddr,
  output logic       [`NSX_DATA_W-1:0]    file_wdata,
  // architectural state
  output logic       [`NSX_DATA_W-1:0]    acc,
  output logic                            zero_flag,
  output logic       [`NSX_DATA_W-1:0]    dir_port_a,
  output logic       [`NSX_DATA_W-1:0]    dir_port_b,
  // completion pulse, one cycle after issue
  output logic                            done
);

  typedef struct packed {
    logic [`NSX_DATA_W-1:0] acc;
    logic                   zero_flag;
    logic [`NSX_DATA_W-1:0] dir_port_a;
    logic [`NSX_DATA_W-1:0] dir_port_b;
    logic                   file_we;
    logic [`NSX_ADDR_W-1:0] file_waddr;
    logic [`NSX_DATA_W-1:0] file_wdata;
    logic                   done;
  } nsx_state_struct_type;

  nsx_state_struct_type   state;
  nsx_state_struct_type   next_state;
  logic [`NSX_DATA_W-1:0] alu_result;
  logic                   alu_zero;
  nsx_pkg::nsx_op_type    alu_op;

  assign alu_op = issue ? op : nsx_pkg::nsx_op_none;

  nsx_alu u_alu (
    .op        (alu_op),
    .acc       (state.acc),
    .file_data (file_rdata),
    .literal   (literal),
    .result    (alu_result),
    .zero      (alu_zero)
  );

  always_comb begin
    next_state            = state;
    next_state.file_we    = 1'b0;
    next_state.done       = 1'b0;
    if (issue) begin
      next_state.done = 1'b1;
      case (op)
        nsx_pkg::nsx_op_nibble_swap: begin // RL1
          if (dest_sel == `NSX_DEST_ACC) begin
            next_state.acc = alu_result; // RL2
          end else begin
            next_state.file_we    = 1'b1; // RL2
            next_state.file_waddr = file_addr;
            next_state.file_wdata = alu_result;
          end
        end
        nsx_pkg::nsx_op_direction_load: begin
          if (file_addr == `NSX_DIR_PORT_A) begin
            next_state.dir_port_a = state.acc; // RL3
          end else if (file_addr == `NSX_DIR_PORT_B) begin
            next_state.dir_port_b = state.acc; // RL3
          end
        end
        nsx_pkg::nsx_op_xor_literal: begin
          next_state.acc       = alu_result; // RL4
          next_state.zero_flag = alu_zero; // RL7
        end
        nsx_pkg::nsx_op_xor_file: begin
          next_state.zero_flag = alu_zero; // RL5
          if (dest_sel == `NSX_DEST_ACC) begin
            next_state.acc = alu_result; // RL6
          end else begin
            next_state.file_we    = 1'b1; // RL6
            next_state.file_waddr = file_addr;
            next_state.file_wdata = alu_result;
          end
        end
        default: begin
          next_state.done = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state.acc        <= `NSX_ACC_RESET;
      state.zero_flag  <= 1'b0;
      state.dir_port_a <= `NSX_DIR_RESET;
      state.dir_port_b <= `NSX_DIR_RESET;
      state.file_we    <= 1'b0;
      state.file_waddr <= 5'h00;
      state.file_wdata <= 8'h00;
      state.done       <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign acc        = state.acc;
  assign zero_flag  = state.zero_flag;
  assign dir_port_a = state.dir_port_a;
  assign dir_port_b = state.dir_port_b;
  assign file_we    = state.file_we;
  assign file_waddr = state.file_waddr;
  assign file_wdata = state.file_wdata;
  assign done       = state.done;

endmodule // nsx_exec

//--- tb/nsx_exec_checker.sv
// assertion checker for the nsx execution unit
`timescale 1ns/1ps
module nsx_checker (
  input wire logic sys_clk, rst_n, issue, dest_sel, file_we, zero_flag, done,
  input wire nsx_pkg::nsx_op_type op,
  input wire logic [4:0] file_addr, file_waddr,
  input wire logic [7:0] literal, file_rdata, file_wdata, acc, dir_port_a, dir_port_b
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire sw = issue && op == nsx_pkg::nsx_op_nibble_swap;
  wire xf = issue && op == nsx_pkg::nsx_op_xor_file;
  wire xl = issue && op == nsx_pkg::nsx_op_xor_literal;
  a_swap_nibble_order: assert property (sw && !dest_sel |=> done && $stable(zero_flag)
    && acc == {$past(file_rdata[3:0]), $past(file_rdata[7:4])}) else $error("swap result wrong");
  a_swap_file_dest: assert property (sw && dest_sel |=> file_we && $stable(acc)
    && file_wdata == {$past(file_rdata[3:0]), $past(file_rdata[7:4])}) else $error("swap dest");
  a_dir_load_copy: assert property (issue && op == nsx_pkg::nsx_op_direction_load
    && file_addr[4:1] == 4'h3 |=> $stable(zero_flag) && $past(acc) ==
    ($past(file_addr[0]) ? dir_port_b : dir_port_a)) else $error("direction load wrong");
  a_xor_literal_acc: assert property (xl |=> done && acc == ($past(acc) ^ $past(literal)))
    else $error("xor literal wrong");
  a_xor_file_acc: assert property (xf && !dest_sel |=> !file_we
    && acc == ($past(acc) ^ $past(file_rdata))) else $error("xor file to acc wrong");
  a_xor_file_back: assert property (xf && dest_sel |=> file_we && $stable(acc)
    && file_waddr == $past(file_addr) && file_wdata == ($past(acc) ^ $past(file_rdata)))
    else $error("xor file write-back wrong");
  a_zero_flag_value: assert property (xl || xf |=> zero_flag ==
    (($past(acc) ^ ($past(xl) ? $past(literal) : $past(file_rdata))) == 8'h00))
    else $error("zero flag wrong");
  c_file_write: cover property (file_we);
  c_zero_set: cover property (zero_flag);
  c_dir_b: cover property ($changed(dir_port_b));
endmodule // nsx_checker
bind nsx_exec nsx_checker u_chk (
  .sys_clk    (sys_clk),
  .rst_n      (rst_n),
  .issue      (issue),
  .dest_sel   (dest_sel),
  .file_we    (file_we),
  .zero_flag  (zero_flag),
  .done       (done),
  .op         (op),
  .file_addr  (file_addr),
  .file_waddr (file_waddr),
  .literal    (literal),
  .file_rdata (file_rdata),
  .file_wdata (file_wdata),
  .acc        (acc),
  .dir_port_a (dir_port_a),
  .dir_port_b (dir_port_b)
);

//--- tb/nsx_exec_tb.sv
// self-checking bench for the nsx execution unit
`timescale 1ns/1ps
module nsx_exec_tb;
  logic sys_clk = 0, rst_n = 0, issue = 0, dest_sel = 0, file_we, zero_flag, done;
  nsx_pkg::nsx_op_type op = nsx_pkg::nsx_op_none;
  logic [4:0] file_addr = 5'h00, file_waddr;
  logic [7:0] literal = 8'h00, file_rdata = 8'h00, file_wdata, acc, dir_port_a, dir_port_b;
  int bad_count = 0, samples_checked = 0, cycles = 0;
  always #50 sys_clk = ~sys_clk;
  nsx_exec dut (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .issue      (issue),
    .op         (op),
    .file_addr  (file_addr),
    .dest_sel   (dest_sel),
    .literal    (literal),
    .file_rdata (file_rdata),
    .file_we    (file_we),
    .file_waddr (file_waddr),
    .file_wdata (file_wdata),
    .acc        (acc),
    .zero_flag  (zero_flag),
    .dir_port_a (dir_port_a),
    .dir_port_b (dir_port_b),
    .done       (done)
  );
  task automatic summarize;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 400) begin
      bad_count++;
      summarize();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // issue one instruction; returns once its results are visible
  task automatic run(input nsx_pkg::nsx_op_type o, input logic [4:0] a, input logic d,
                     input logic [7:0] k, input logic [7:0] r);
    @(posedge sys_clk);
    #1 issue = 1'b1;
    op = o;
    file_addr = a;
    dest_sel = d;
    literal = k;
    file_rdata = r;
    @(posedge sys_clk);
    #1 issue = 0;
    chk({7'h00, done}, 8'h01);
  endtask
  task automatic test_xor_literal;
    run(nsx_pkg::nsx_op_xor_literal, 5'h00, 1'b0, 8'hA5, 8'h00);
    chk(acc, 8'hA5);
    chk({7'h00, zero_flag}, 8'h00);
    run(nsx_pkg::nsx_op_xor_literal, 5'h00, 1'b1, 8'hA5, 8'hFF);
    chk(acc, 8'h00);
    chk({7'h00, zero_flag}, 8'h01);
  endtask
  task automatic test_direction;
    run(nsx_pkg::nsx_op_direction_load, 5'h06, 1'b0, 8'h00, 8'h00);
    chk(dir_port_a, 8'h00);
    run(nsx_pkg::nsx_op_xor_literal, 5'h00, 1'b0, 8'hC3, 8'h00);
    run(nsx_pkg::nsx_op_direction_load, 5'h07, 1'b0, 8'h00, 8'h00);
    chk(dir_port_b, 8'hC3);
    chk(dir_port_a, 8'h00);
    run(nsx_pkg::nsx_op_direction_load, 5'h05, 1'b0, 8'h00, 8'h00);
    chk(dir_port_a, 8'h00);
    chk(dir_port_b, 8'hC3);
  endtask
  task automatic test_xor_file;
    run(nsx_pkg::nsx_op_xor_file, 5'h1F, 1'b0, 8'h00, 8'hC3);
    chk(acc, 8'h00);
    chk({7'h00, zero_flag}, 8'h01);
    run(nsx_pkg::nsx_op_xor_file, 5'h11, 1'b1, 8'h00, 8'h5A);
    chk({file_we, 2'h0, file_waddr}, 8'h91);
    chk(file_wdata, 8'h5A);
    chk({zero_flag, acc[6:0]}, 8'h00);
  endtask
  task automatic test_swap;
    run(nsx_pkg::nsx_op_nibble_swap, 5'h03, 1'b0, 8'h00, 8'h12);
    chk(acc, 8'h21);
    run(nsx_pkg::nsx_op_nibble_swap, 5'h1F, 1'b1, 8'h00, 8'h00);
    chk({file_we, 2'h0, file_waddr}, 8'h9F);
    chk(file_wdata, 8'h00);
    chk({zero_flag, acc[6:0]}, 8'h21);
  endtask
  // two xor literals on consecutive edges; the second must see the first result
  task automatic test_back_to_back;
    @(posedge sys_clk);
    #1 issue = 1'b1;
    op = nsx_pkg::nsx_op_xor_literal;
    literal = 8'h0F;
    @(posedge sys_clk);
    #1 literal = 8'hF0;
    @(posedge sys_clk);
    #1 issue = 1'b0;
    chk({7'h00, done}, 8'h01);
    chk(acc, 8'hDE);
    chk({7'h00, zero_flag}, 8'h00);
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    #1 rst_n = 1;
    chk(dir_port_b, 8'hFF);
    test_xor_literal();
    test_direction();
    test_xor_file();
    test_swap();
    test_back_to_back();
    summarize();
  end
endmodule // nsx_exec_tb
